// >>> rtl/ioc_defs.svh
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IOC_IDX_CLKSEL 10'h08F
`define IOC_IDX_MULT 10'h097
`define IOC_IDX_FINE 10'h09E
`define IOC_IDX_CTRL 10'h0A1
`define IOC_IDX_COARSE 10'h0A2
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define IOC_CTRL_RST 8'hD0
`define IOC_EN_ON 2'h3
`define IOC_BIT_SUSP 5
`define IOC_BIT_RDY 4
`define IOC_BIT_MRDY 5
`define IOC_DIV_RST 3'h0
`define IOC_COARSE_CAL 7'h40
`define IOC_FINE_CAL 6'h20
`define IOC_SRC_RST 2'h0
`define IOC_RESP_OKAY 2'h0
`define IOC_RESP_DECERR 2'h3
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IOC_CLK_MHZ 100
`define IOC_SETTLE_NS 200
`define IOC_SETTLE_CYC ((`IOC_SETTLE_NS * `IOC_CLK_MHZ + 999) / 1000)
`define IOC_LOCK_NS 1000
`define IOC_LOCK_CYC ((`IOC_LOCK_NS * `IOC_CLK_MHZ + 999) / 1000)
`define IOC_BURST_LEN 4'h8
`endif

// >>> rtl/ioc_pkg.sv
package ioc_pkg;
  // multiplier register image, msb first
  typedef struct packed {
    logic en;
    logic init;
    logic rdy;
    logic [2:0] scale;
    logic [1:0] sel;
  } ioc_mult_cfg_s;

  typedef struct packed {
    logic [6:0] coarse;
    logic [5:0] fine;
  } ioc_trim_s;

  typedef enum logic [1:0] {
    IOC_SRC_INT = 2'h0,
    IOC_SRC_EXT = 2'h1,
    IOC_SRC_MULT = 2'h2,
    IOC_SRC_RSVD = 2'h3
  } ioc_src_e;

  typedef enum logic [3:0] {
    IOC_OSC_OFF = 4'h1,
    IOC_OSC_SETTLE = 4'h2,
    IOC_OSC_RUN = 4'h4,
    IOC_OSC_SUSP = 4'h8
  } ioc_osc_st_e;

  typedef enum logic [3:0] {
    IOC_MUL_OFF = 4'h1,
    IOC_MUL_WAIT = 4'h2,
    IOC_MUL_LOCK = 4'h4,
    IOC_MUL_RDY = 4'h8
  } ioc_mul_st_e;
endpackage : ioc_pkg

// >>> rtl/ioc_mult.sv
`timescale 1ns/1ns
`include "ioc_defs.svh"
module ioc_mult (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire ioc_pkg::ioc_mult_cfg_s cfg_i,
  input wire logic init_i,
  input wire logic int_run_i,
  input wire logic ext_osc_i,
  output logic ready_o,
  output logic pulse_o,
  output logic [2:0] den_o
);
  localparam int LOCK_D = `IOC_LOCK_CYC;
  localparam int LOCK_LO = LOCK_D - 9;
  ioc_pkg::ioc_mul_st_e st_q;
  logic [7:0] lock_q;
  logic int_half_q, ext_half_q, ext_d_q, ref_d_q, ref_w;
  logic [3:0] burst_q;

  // ----------------------------------------------------------------
  // enable, initialize, lock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= ioc_pkg::IOC_MUL_OFF;
      lock_q <= 8'h00;
    end else if (!cfg_i.en) begin
      st_q <= ioc_pkg::IOC_MUL_OFF;
    end else begin
      case (st_q)
        ioc_pkg::IOC_MUL_OFF: st_q <= ioc_pkg::IOC_MUL_WAIT;
        ioc_pkg::IOC_MUL_LOCK: begin
          lock_q <= lock_q - 8'h01;
          if (lock_q == 8'h01) st_q <= ioc_pkg::IOC_MUL_RDY;
        end
        default: ;
      endcase
      if (init_i) begin // re-init restarts the lock wait
        st_q <= ioc_pkg::IOC_MUL_LOCK;
        lock_q <= 8'(`IOC_LOCK_CYC);
      end
    end
  end
  assign ready_o = (st_q == ioc_pkg::IOC_MUL_RDY);

  // ----------------------------------------------------------------
  // input choice and halving
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      int_half_q <= 1'b0;
      ext_half_q <= 1'b0;
      ext_d_q <= 1'b0;
      ref_d_q <= 1'b0;
    end else begin
      ext_d_q <= ext_osc_i;
      ref_d_q <= ref_w;
      if (int_run_i) int_half_q <= ~int_half_q; // internal osc modelled at clk rate
      if (ext_osc_i && !ext_d_q) ext_half_q <= ~ext_half_q;
    end
  end
  always_comb begin
    case (cfg_i.sel)
      2'h0: ref_w = int_half_q;
      2'h1: ref_w = ext_osc_i;
      default: ref_w = ext_half_q;
    endcase
  end

  // ----------------------------------------------------------------
  // four fast pulses per reference edge; edges inside a burst are lost
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      burst_q <= 4'h0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= burst_q[0];
      if (burst_q != 4'h0) burst_q <= burst_q - 4'h1;
      else if (ready_o && ref_w && !ref_d_q) burst_q <= `IOC_BURST_LEN;
    end
  end

  // output ratio is 4 * 2 / den_o
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) den_o <= 3'h2;
    else den_o <= (cfg_i.scale < 3'h3) ? 3'h2 : cfg_i.scale;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_four;
    pulse_o ##1 !pulse_o ##1 pulse_o ##1 !pulse_o ##1 pulse_o ##1 !pulse_o ##1 pulse_o ##1 !pulse_o;
  endsequence
  property p_burst;
    burst_q == 4'h0 && ready_o && ref_w && !ref_d_q && cfg_i.en |-> ##3 s_four;
  endproperty
  a_burst: assert property (p_burst) else $error("burst is not four pulses");
  property p_lock;
    init_i && cfg_i.en |=> !ready_o [*2];
  endproperty
  a_lock: assert property (p_lock) else $error("ready too early after init");
  property p_lock_time;
    cfg_i.en && init_i ##1 (cfg_i.en && !init_i) [*8] |-> ##[LOCK_LO:LOCK_D] ready_o;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock time wrong");
  property p_off;
    !cfg_i.en |=> !ready_o;
  endproperty
  a_off: assert property (p_off) else $error("ready while disabled");
  property p_den;
    cfg_i.scale == 3'h7 |=> den_o == 3'h7;
  endproperty
  a_den: assert property (p_den) else $error("scale not applied");
endmodule : ioc_mult

// >>> rtl/ioc_top.sv
// Summary of operation
// - enable code 00 stops the oscillator, 11 runs it unless suspended
// - writing suspend halts the oscillator until a wake-up event restarts it
// - frequency-ready reads one only while running at programmed frequency
// - control bit 3 reads zero; software writes zero
// - divider code 000 gives divide by 128, down to 1 for 111
// - seven-bit coarse trim sets oscillator period, zero slowest, all ones fastest
// - coarse trim top bit reads zero, writes ignored
// - six-bit fine trim adds small period adjustments
// - fine trim upper two bits read zero, writes ignored
// - trims load calibrated values at reset for nominal frequency
// - multiplier outputs four times input, scaled by selectable factor
// - multiplier input is external, internal halved, or external halved
// - multiplier ready rises once output stabilizes after initialize
// - slow input gives four fast pulses per input period
// - wake-up is a port 0-3 match or enabled comparator 0 low
// - source code 10 selects multiplier, 00 internal divided, 01 external
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`include "ioc_defs.svh"
module ioc_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [3:0] port_match_i,
  input wire logic cmp0_en_i,
  input wire logic cmp0_out_i,
  input wire logic ext_osc_i,
  output logic osc_run_o,
  output logic freq_ready_flag_o,
  output ioc_pkg::ioc_trim_s trim_o,
  output logic [2:0] int_clk_divider_o,
  output logic [1:0] clk_source_select_o,
  output logic core_clock_o,
  output logic core_wake_o,
  output logic mult_ready_o,
  output logic [2:0] mult_den_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [9:0] aw_idx_q, rd_idx_q;
  logic aw_have_q, w_have_q;
  logic [7:0] wdat_q;
  logic wstb_q, wr_go;
  logic [1:0] en_code_q;
  logic suspend_q;
  logic [2:0] div_q;
  ioc_pkg::ioc_mult_cfg_s mult_q;
  ioc_pkg::ioc_src_e src_q;
  ioc_pkg::ioc_osc_st_e osc_q;
  logic [7:0] settle_q;
  logic [6:0] div_cnt_q;
  logic wake, div_tick, ext_d_q, mult_pulse, mult_init;
  logic wr_ctrl, wr_mult, wr_known;
  logic [7:0] rd_byte;
  logic rd_known;

  // register index from a byte address
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx);
  endfunction : hit

  // divider mask: a tick every 2^(7-code) oscillator cycles
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'h7F >> code;
  endfunction : div_mask

  // ----------------------------------------------------------------
  // bus slave: write side, address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !aw_have_q && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_have_q && !s_axi_bvalid_o;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid_o;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 10'h000;
      wdat_q <= 8'h00;
      wstb_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr_i[11:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        wdat_q <= s_axi_wdata_i[7:0];
        wstb_q <= s_axi_wstrb_i[0]; // registers live in byte lane 0 only
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_known = 1'b0;
    case (aw_idx_q)
      `IOC_IDX_CLKSEL, `IOC_IDX_MULT, `IOC_IDX_FINE, `IOC_IDX_CTRL, `IOC_IDX_COARSE: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end
  assign wr_ctrl = wr_go && wstb_q && hit({aw_idx_q, 2'h0}, `IOC_IDX_CTRL);
  assign wr_mult = wr_go && wstb_q && hit({aw_idx_q, 2'h0}, `IOC_IDX_MULT);

  // write response one cycle after both halves are held
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `IOC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_known ? `IOC_RESP_OKAY : `IOC_RESP_DECERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus slave: read side
  // ----------------------------------------------------------------
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_comb begin
    rd_byte = 8'h00;
    rd_known = 1'b1;
    if (hit(s_axi_araddr_i, `IOC_IDX_CTRL))
      rd_byte = {en_code_q, suspend_q, freq_ready_flag_o, 1'b0, div_q};
    else if (hit(s_axi_araddr_i, `IOC_IDX_COARSE))
      rd_byte = {1'b0, trim_o.coarse};
    else if (hit(s_axi_araddr_i, `IOC_IDX_FINE))
      rd_byte = {2'h0, trim_o.fine};
    else if (hit(s_axi_araddr_i, `IOC_IDX_MULT))
      rd_byte = {mult_q.en, mult_q.init, mult_ready_o, mult_q.scale, mult_q.sel};
    else if (hit(s_axi_araddr_i, `IOC_IDX_CLKSEL))
      rd_byte = {6'h00, src_q};
    else
      rd_known = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `IOC_RESP_OKAY;
      rd_idx_q <= 10'h000;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, rd_byte};
      s_axi_rresp_o <= rd_known ? `IOC_RESP_OKAY : `IOC_RESP_DECERR;
      rd_idx_q <= s_axi_araddr_i[11:2];
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // oscillator control register; a write of suspend beats a wake event
  // ----------------------------------------------------------------
  assign wake = (|port_match_i) || (cmp0_en_i && !cmp0_out_i);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_code_q <= 2'(`IOC_CTRL_RST >> 6);
      suspend_q <= 1'b0;
      div_q <= `IOC_DIV_RST;
    end else if (wr_ctrl) begin
      en_code_q <= wdat_q[7:6];
      suspend_q <= wdat_q[`IOC_BIT_SUSP];
      div_q <= wdat_q[2:0]; // bit 3 dropped
    end else if (suspend_q && wake) begin
      suspend_q <= 1'b0;
    end
  end

  // wake strobe lets the core resume after the suspend write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) core_wake_o <= 1'b0;
    else core_wake_o <= suspend_q && wake && !wr_ctrl;
  end

  // ----------------------------------------------------------------
  // oscillator state; reserved enable codes are treated as off
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_q <= ioc_pkg::IOC_OSC_RUN;
      settle_q <= 8'h00;
    end else if (en_code_q != `IOC_EN_ON) begin
      osc_q <= ioc_pkg::IOC_OSC_OFF;
    end else if (suspend_q) begin
      osc_q <= ioc_pkg::IOC_OSC_SUSP;
    end else begin
      case (osc_q)
        ioc_pkg::IOC_OSC_OFF, ioc_pkg::IOC_OSC_SUSP: begin
          osc_q <= ioc_pkg::IOC_OSC_SETTLE;
          settle_q <= 8'(`IOC_SETTLE_CYC);
        end
        ioc_pkg::IOC_OSC_SETTLE: begin
          settle_q <= settle_q - 8'h01;
          if (settle_q == 8'h01) osc_q <= ioc_pkg::IOC_OSC_RUN;
        end
        ioc_pkg::IOC_OSC_RUN: osc_q <= ioc_pkg::IOC_OSC_RUN;
        default: osc_q <= ioc_pkg::IOC_OSC_OFF;
      endcase
    end
  end
  assign osc_run_o = (osc_q == ioc_pkg::IOC_OSC_RUN) || (osc_q == ioc_pkg::IOC_OSC_SETTLE);
  assign freq_ready_flag_o = (osc_q == ioc_pkg::IOC_OSC_RUN);
  assign int_clk_divider_o = div_q;

  // ----------------------------------------------------------------
  // trims drive the analog period; calibrated at reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      trim_o.coarse <= `IOC_COARSE_CAL;
      trim_o.fine <= `IOC_FINE_CAL;
    end else if (wr_go && wstb_q) begin
      if (hit({aw_idx_q, 2'h0}, `IOC_IDX_COARSE)) trim_o.coarse <= wdat_q[6:0];
      if (hit({aw_idx_q, 2'h0}, `IOC_IDX_FINE)) trim_o.fine <= wdat_q[5:0];
    end
  end

  // ----------------------------------------------------------------
  // multiplier register and clock source select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mult_q <= '0;
      src_q <= ioc_pkg::IOC_SRC_INT;
    end else begin
      if (wr_mult) begin
        mult_q <= wdat_q;
        mult_q.rdy <= 1'b0; // status lives in the multiplier
      end
      if (wr_go && wstb_q && hit({aw_idx_q, 2'h0}, `IOC_IDX_CLKSEL))
        src_q <= ioc_pkg::ioc_src_e'(wdat_q[1:0]);
    end
  end
  assign clk_source_select_o = src_q;
  // init only counts when the same write keeps the enable set
  assign mult_init = wr_mult && wdat_q[7] && wdat_q[6];

  ioc_mult u_mult (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cfg_i(mult_q),
    .init_i(mult_init),
    .int_run_i(osc_run_o),
    .ext_osc_i(ext_osc_i),
    .ready_o(mult_ready_o),
    .pulse_o(mult_pulse),
    .den_o(mult_den_o)
  );

  // ----------------------------------------------------------------
  // core clock as a one-cycle tick per source period
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) div_cnt_q <= 7'h00;
    else if (osc_run_o) div_cnt_q <= div_cnt_q + 7'h01;
  end
  assign div_tick = osc_run_o && ((div_cnt_q & div_mask(div_q)) == div_mask(div_q));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_d_q <= 1'b0;
      core_clock_o <= 1'b0;
    end else begin
      ext_d_q <= ext_osc_i;
      case (src_q)
        ioc_pkg::IOC_SRC_INT: core_clock_o <= div_tick;
        ioc_pkg::IOC_SRC_EXT: core_clock_o <= ext_osc_i && !ext_d_q;
        ioc_pkg::IOC_SRC_MULT: core_clock_o <= mult_pulse;
        default: core_clock_o <= 1'b0; // reserved code stops the clock
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_off;
    en_code_q != `IOC_EN_ON |=> !freq_ready_flag_o && !osc_run_o;
  endproperty
  a_off: assert property (p_off) else $error("oscillator alive while disabled");
  property p_susp;
    suspend_q |=> !osc_run_o;
  endproperty
  a_susp: assert property (p_susp) else $error("oscillator runs in suspend");
  property p_wake;
    suspend_q && wake && !wr_ctrl |=> !suspend_q && core_wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake event missed");
  sequence s_resume;
    !freq_ready_flag_o ##1 freq_ready_flag_o;
  endsequence
  property p_resume;
    s_resume |-> $past(osc_q == ioc_pkg::IOC_OSC_SETTLE) && $past(settle_q) == 8'h01;
  endproperty
  a_resume: assert property (p_resume) else $error("ready before settling");
  property p_rsvd;
    s_axi_rvalid_o && rd_idx_q == `IOC_IDX_CTRL |-> s_axi_rdata_o[3] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
  property p_trim_hi;
    s_axi_rvalid_o && rd_idx_q == `IOC_IDX_FINE |-> s_axi_rdata_o[7:6] == 2'h0;
  endproperty
  a_trim_hi: assert property (p_trim_hi) else $error("fine trim top bits set");
  property p_div128;
    div_tick && div_q == 3'h0 |=> !div_tick [*8];
  endproperty
  a_div128: assert property (p_div128) else $error("divide by 128 ticks too soon");
  property p_trim_rst;
    $past(sys_rst_i) |-> trim_o.coarse == `IOC_COARSE_CAL && trim_o.fine == `IOC_FINE_CAL;
  endproperty
  a_trim_rst: assert property (p_trim_rst) else $error("trim not calibrated");
  property p_src;
    src_q == ioc_pkg::IOC_SRC_MULT && $stable(src_q) |=> core_clock_o == $past(mult_pulse);
  endproperty
  a_src: assert property (p_src) else $error("multiplier not routed");
endmodule : ioc_top

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`include "ioc_defs.svh"
module tb_top;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] pmatch = 4'h0, wstrb = 4'hF;
  logic cmp_en = 1'h0, cmp_out = 1'h1, ext_osc = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, osc_run, frdy, core_clk, wake, mrdy;
  logic [1:0] bresp, rresp, src;
  logic [2:0] div, den;
  ioc_pkg::ioc_trim_s trim;
  int n_fail = 0;
  int comparisons = 0;
  logic [1:0] rs;
  logic [31:0] rd;
  int c;

  always #5 clk_i = ~clk_i;

  ioc_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_match_i(pmatch),
    .cmp0_en_i(cmp_en), .cmp0_out_i(cmp_out), .ext_osc_i(ext_osc), .osc_run_o(osc_run),
    .freq_ready_flag_o(frdy), .trim_o(trim), .int_clk_divider_o(div), .clk_source_select_o(src),
    .core_clock_o(core_clk), .core_wake_o(wake), .mult_ready_o(mrdy), .mult_den_o(den));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic hang(input string name);
    n_fail++;
    $display("mismatch %s expected response seen none", name);
    finish_test();
  endtask : hang

  // ----------------------------------------------------------------
  // bus master: each channel released at the edge that takes it
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
    int n;
    logic a, w;
    a = 1'h0;
    w = 1'h0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      if (!a && awready) begin a = 1'h1; awvalid <= 1'h0; end
      if (!w && wready) begin w = 1'h1; wvalid <= 1'h0; end
      if (bvalid) begin resp = bresp; bready <= 1'h0; break; end
    end
    if (n == 200) hang("write");
    @(posedge clk_i); // one idle edge so the next call never re-raises bready in this step
  endtask : wr

  task automatic rd_reg(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int n;
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin d = rdata; resp = rresp; rready <= 1'h0; break; end
    end
    if (n == 200) hang("read");
    @(posedge clk_i); // one idle edge before the next request
  endtask : rd_reg

  // write then read back, both answers checked
  task automatic wr_rd(input logic [9:0] idx, input logic [7:0] d, input logic [7:0] exp);
    wr(idx, d, rs);
    chk("write resp", `IOC_RESP_OKAY, rs);
    rd_reg(idx, rd, rs);
    chk("read data", {24'h0, exp}, rd);
  endtask : wr_rd

  task automatic ticks(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin @(posedge clk_i); if (core_clk === 1'h1) cnt++; end
  endtask : ticks

  // bounded wait: 0 freq ready, 1 multiplier ready, 2 wake pulse
  task automatic wait_hi(input int sel, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk_i);
      if ((sel == 0 ? frdy : sel == 1 ? mrdy : wake) === 1'h1) break;
    end
    if (n == lim) hang("flag");
  endtask : wait_hi

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    chk("ready after reset", 1'h1, frdy);
    rd_reg(`IOC_IDX_CTRL, rd, rs);
    chk("ctrl reset", 32'hD0, rd);
    rd_reg(`IOC_IDX_COARSE, rd, rs);
    chk("coarse reset", {25'h0, `IOC_COARSE_CAL}, rd);
    rd_reg(`IOC_IDX_FINE, rd, rs);
    chk("fine reset", {26'h0, `IOC_FINE_CAL}, rd);
    wr_rd(`IOC_IDX_COARSE, 8'hFF, 8'h7F);
    chk("coarse out", 7'h7F, trim.coarse);
    wr_rd(`IOC_IDX_FINE, 8'hFF, 8'h3F);
    chk("fine out", 6'h3F, trim.fine);
    wr_rd(`IOC_IDX_COARSE, 8'h00, 8'h00);
    // lane 0 strobe low: write is answered but ignored
    wstrb <= 4'h0;
    wr(`IOC_IDX_COARSE, 8'h11, rs);
    wstrb <= 4'hF;
    chk("masked write resp", `IOC_RESP_OKAY, rs);
    rd_reg(`IOC_IDX_COARSE, rd, rs);
    chk("masked write", 32'h0, rd);
    // reserved bit is written as zero and must read zero
    wr_rd(`IOC_IDX_CTRL, 8'hC0, 8'hD0);
    rd_reg(10'h000, rd, rs);
    chk("unmapped resp", `IOC_RESP_DECERR, rs);
    chk("unmapped data", 32'h0, rd);
    wr(10'h000, 8'h00, rs);
    chk("unmapped wr resp", `IOC_RESP_DECERR, rs);
    // each divider code: ticks over 256 cycles equal 256 >> (7 - code)
    for (int k = 0; k < 8; k++) begin
      wr(`IOC_IDX_CTRL, 8'hC0 | k[7:0], rs);
      repeat (130) @(posedge clk_i);
      ticks(256, c);
      chk("divider ticks", 256 >> (7 - k), c);
      chk("divider out", k[2:0], div);
    end
    wr(`IOC_IDX_CTRL, 8'h07, rs);
    repeat (2) @(posedge clk_i);
    chk("off ready", 1'h0, frdy);
    chk("off run", 1'h0, osc_run);
    ticks(16, c);
    chk("off ticks", 0, c);
    wr(`IOC_IDX_CTRL, 8'hC7, rs);
    repeat (2) @(posedge clk_i);
    chk("settling ready", 1'h0, frdy);
    wait_hi(0, 40);
    wr_rd(`IOC_IDX_CTRL, 8'hC7, 8'hD7);
    // comparator high is no wake event, so suspend must hold
    cmp_en <= 1'h1;
    for (int k = 0; k < 5; k++) begin
      wr(`IOC_IDX_CTRL, 8'hE7, rs);
      repeat (12) @(posedge clk_i);
      chk("suspended ready", 1'h0, frdy);
      if (k < 4) pmatch <= 4'h1 << k;
      else cmp_out <= 1'h0;
      wait_hi(2, 10);
      pmatch <= 4'h0;
      cmp_out <= 1'h1;
      wait_hi(0, 40);
    end
    rd_reg(`IOC_IDX_CTRL, rd, rs);
    chk("woken ctrl", 32'hD7, rd);
    // multiplier bring-up on the external input
    wr_rd(`IOC_IDX_MULT, 8'h00, 8'h00);
    wr_rd(`IOC_IDX_MULT, 8'h81, 8'h81);
    repeat (600) @(posedge clk_i);
    chk("not yet ready", 1'h0, mrdy);
    wr(`IOC_IDX_MULT, 8'hC1, rs);
    chk("ready early", 1'h0, mrdy);
    wait_hi(1, 200);
    rd_reg(`IOC_IDX_MULT, rd, rs);
    chk("mult reg", 32'hE1, rd);
    for (int k = 0; k < 3; k++) begin
      wr_rd(`IOC_IDX_CLKSEL, k[7:0], k[7:0]);
      chk("source out", k[1:0], src);
    end
    // slow reference: four pulses per rising edge
    c = 0;
    repeat (4) begin
      ext_osc <= 1'h1;
      ticks(20, rd);
      c += rd;
      ext_osc <= 1'h0;
      ticks(20, rd);
      c += rd;
    end
    chk("burst ticks", 16, c);
    for (int k = 0; k < 8; k++) begin
      wr(`IOC_IDX_MULT, 8'hC1 | (k[7:0] << 2), rs);
      repeat (2) @(posedge clk_i);
      chk("scale den", (k < 3) ? 3'h2 : k[2:0], den);
    end
    wr(`IOC_IDX_MULT, 8'h00, rs);
    repeat (2) @(posedge clk_i);
    chk("disabled mult", 1'h0, mrdy);
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    hang("run length");
  end
endmodule : tb_top
